// >>> hdl/tfr_consts.svh
// register offsets, field positions, reset values and the fan failure count
`ifndef TFR_CONSTS_SVH
`define TFR_CONSTS_SVH

`define TFR_ADDR_CFG1 8'h00
`define TFR_ADDR_CFG2 8'h01
`define TFR_ADDR_FLAGS1 8'h02
`define TFR_ADDR_FLAGS2 8'h03
`define TFR_ADDR_FRACTION 8'h06
`define TFR_ADDR_FACTORY 8'h07
`define TFR_ADDR_FAN_COUNT 8'h08
`define TFR_ADDR_LOCAL_TEMP 8'h0A
`define TFR_ADDR_REMOTE_TEMP 8'h0B
`define TFR_ADDR_LOCAL_OFS 8'h0D
`define TFR_ADDR_REMOTE_OFS 8'h0E
`define TFR_ADDR_FAN_LIMIT 8'h10
`define TFR_ADDR_LOCAL_HIGH 8'h14
`define TFR_ADDR_LOCAL_LOW 8'h15
`define TFR_ADDR_LOCAL_OVT 8'h16
`define TFR_ADDR_REMOTE_HIGH 8'h18
`define TFR_ADDR_REMOTE_LOW 8'h19
`define TFR_ADDR_REMOTE_OVT 8'h1A
`define TFR_ADDR_FAN_SETUP 8'h20
`define TFR_ADDR_FAN_SPEED 8'h22
`define TFR_ADDR_FAN_SMOOTH 8'h23
`define TFR_ADDR_LOCAL_RANGE 8'h24
`define TFR_ADDR_REMOTE_RANGE 8'h25
`define TFR_ADDR_PART_ID 8'h3D
`define TFR_ADDR_MAKER_ID 8'h3E
`define TFR_ADDR_REVISION 8'h3F

// control_config_one fields
`define TFR_CFG1_MONITOR 0
`define TFR_CFG1_INT_EN 1
`define TFR_CFG1_ANALOG 2
`define TFR_CFG1_INVERT 3
`define TFR_CFG1_FAIL_EN 4
`define TFR_CFG1_SRC_LO 5
`define TFR_CFG1_SRC_HI 6
`define TFR_CFG1_AUTO 7

// control_config_two fields
`define TFR_CFG2_LOCAL_INT 4
`define TFR_CFG2_REMOTE_INT 5
`define TFR_CFG2_SOFT_RESET 7

// event_flags_one fields
`define TFR_FLAG1_FAN_FAIL 1
`define TFR_FLAG1_DIODE 5

`define TFR_RST_CFG1 8'h90
`define TFR_RST_CFG2 8'h7F
`define TFR_RST_FAN_LIMIT 8'hFF
`define TFR_RST_LOCAL_HIGH 8'h3C
`define TFR_RST_LOCAL_LOW 8'h00
`define TFR_RST_LOCAL_OVT 8'h46
`define TFR_RST_REMOTE_HIGH 8'h50
`define TFR_RST_REMOTE_LOW 8'h00
`define TFR_RST_REMOTE_OVT 8'h64
`define TFR_RST_FAN_SETUP 8'h5D
`define TFR_RST_FAN_SPEED 8'h55
`define TFR_RST_FAN_SMOOTH 8'h55
`define TFR_RST_LOCAL_RANGE 8'h41
`define TFR_RST_REMOTE_RANGE 8'h61

// consecutive failed measurements before the fan-failure pin asserts
`define TFR_FAIL_COUNT 3'h5

`endif

// >>> hdl/tfr_pkg.sv
// types shared by the register bank
package tfr_pkg;
  typedef logic [7:0] tfr_byte_t;
  typedef logic [1:0] tfr_source_t;
  typedef enum logic [2:0]
  {
    TFR_FAN_OK = 3'b001,
    TFR_FAN_FAILING = 3'b010,
    TFR_FAN_FAULT = 3'b100
  } tfr_fan_state_t;
endpackage

// >>> hdl/tfr_regs.sv
// register bank of a two-channel temperature monitor and fan controller
// Operation
// (RQ1) config one bit 0 enables monitoring and tach measurement; resets zero
// (RQ2) config one bit 1 gates the active-low interrupt output; resets zero
// (RQ3) config one bit 2: zero digital tach, one analog speed sense
// (RQ4) config one bit 3 inverts the fan drive output; resets zero
// (RQ5) drive low at full duty when not inverted, high when inverted
// (RQ6) config one bit 4 enables the fan-failure pin; resets one
// (RQ7) config one bits 6-5 pick remote temperature or fastest speed
// (RQ8) in software mode code 00 means duty, code 11 means target speed
// (RQ9) config one bit 7: one automatic control, zero software; resets one
// (RQ10) config one at address 00 resets to 90
// (RQ11) address 3D returns a fixed part code, writes ignored
// (RQ12) address 3E returns a fixed maker code
// (RQ13) address 3F bits 3:0 return the silicon revision
// (RQ14) address 3F bit 7 enables overtemperature drive of the fan
// (RQ15) host never touches the factory test register at 07
// (RQ16) address 08 holds latest tach period; slower fan, larger count
// (RQ17) tach limit at 10 resets FF; failure only when count exceeds it
// (RQ18) address 0A shows upper bits of local temperature, read-only
// (RQ19) address 0B shows upper bits of remote temperature, read-only
// (RQ20) address 06 is read-only extended fraction bits
// (RQ21) local high, low, overtemperature limits reset to 60, 0, 70 degrees
// (RQ22) remote high, low, overtemperature limits reset to 80, 0, 100 degrees
// (RQ23) offsets at 0D and 0E are read/write
// (RQ24) fan-failure pin asserts low after five consecutive fan failures
// (RQ25) all registers eight bits; unlisted addresses read zero, no effects
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "tfr_consts.svh"

module tfr_regs
  import tfr_pkg::*;
#(
  parameter tfr_byte_t PART_CODE = 8'hA5,   // arbitrary value
  parameter tfr_byte_t MAKER_CODE = 8'h5A,  // arbitrary value
  parameter logic [3:0] REVISION = 4'h1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic [7:0] local_temp_upper_bits,
  input wire logic [7:0] remote_temp_upper_bits,
  input wire logic [7:0] temp_fraction_in,
  input wire logic [7:0] fan_count_in,
  input wire logic fan_count_valid,
  input wire logic [7:0] flags_one_set,
  input wire logic [1:0] flags_two_set,
  input wire logic fan_drive_on,
  output logic monitor_enable,
  output logic speed_sense_analog_select,
  output logic [1:0] control_source,
  output logic automatic_or_software_control,
  output logic software_sets_duty,
  output logic software_sets_speed,
  output logic overtemp_to_fan_enable,
  output logic fan_drive_out,
  output logic int_n,
  output logic fan_fail_n_out,
  output logic fan_fail_oe
);

  tfr_byte_t cfg1_r, cfg2_r, flags1_r, flags2_r, fan_count_r;
  tfr_byte_t local_ofs_r, remote_ofs_r, fan_limit_r;
  tfr_byte_t local_high_r, local_low_r, local_ovt_r;
  tfr_byte_t remote_high_r, remote_low_r, remote_ovt_r;
  tfr_byte_t fan_setup_r, fan_speed_r, fan_smooth_r;
  tfr_byte_t local_range_r, remote_range_r;
  tfr_byte_t rdata_nxt, flags1_src, flags1_clr, flags2_clr;
  logic ovt_fan_r, soft_reset_r, init;
  logic fan_fail_event, fan_pass_event, local_int, remote_int;
  logic [2:0] fail_run_r;
  tfr_fan_state_t fan_state_r;

  // soft reset restores every register except rdata and soft_reset_r as a power-on reset would
  assign init = reset | soft_reset_r;

  // a measured count above the limit is a failure; equal is still fine
  assign fan_fail_event = fan_count_valid & cfg1_r[`TFR_CFG1_MONITOR]
    & (fan_count_in > fan_limit_r); // RQ17 RQ1
  assign fan_pass_event = fan_count_valid & cfg1_r[`TFR_CFG1_MONITOR]
    & (fan_count_in <= fan_limit_r);

  // configuration registers
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      cfg1_r <= `TFR_RST_CFG1; // RQ10 RQ1 RQ2 RQ3 RQ4 RQ6 RQ9
      cfg2_r <= `TFR_RST_CFG2;
    end
    else if (wr && addr == `TFR_ADDR_CFG1)
    begin
      cfg1_r <= wdata;
    end
    else if (wr && addr == `TFR_ADDR_CFG2)
    begin
      cfg2_r <= wdata;
      // soft reset bit never stores; it reads back as zero
      cfg2_r[`TFR_CFG2_SOFT_RESET] <= 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      soft_reset_r <= 1'b0;
    end
    else
    begin
      soft_reset_r <= wr && addr == `TFR_ADDR_CFG2
        && wdata[`TFR_CFG2_SOFT_RESET];
    end
  end

  // limits, offsets and fan setup registers
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      local_ofs_r <= 8'h00;
      remote_ofs_r <= 8'h00;
      fan_limit_r <= `TFR_RST_FAN_LIMIT; // RQ17
      local_high_r <= `TFR_RST_LOCAL_HIGH; // RQ21
      local_low_r <= `TFR_RST_LOCAL_LOW; // RQ21
      local_ovt_r <= `TFR_RST_LOCAL_OVT; // RQ21
      remote_high_r <= `TFR_RST_REMOTE_HIGH; // RQ22
      remote_low_r <= `TFR_RST_REMOTE_LOW; // RQ22
      remote_ovt_r <= `TFR_RST_REMOTE_OVT; // RQ22
      fan_setup_r <= `TFR_RST_FAN_SETUP;
      fan_speed_r <= `TFR_RST_FAN_SPEED;
      fan_smooth_r <= `TFR_RST_FAN_SMOOTH;
      local_range_r <= `TFR_RST_LOCAL_RANGE;
      remote_range_r <= `TFR_RST_REMOTE_RANGE;
      ovt_fan_r <= 1'b0;
    end
    else if (wr)
    begin
      case (addr)
        `TFR_ADDR_LOCAL_OFS: local_ofs_r <= wdata; // RQ23
        `TFR_ADDR_REMOTE_OFS: remote_ofs_r <= wdata; // RQ23
        `TFR_ADDR_FAN_LIMIT: fan_limit_r <= wdata;
        `TFR_ADDR_LOCAL_HIGH: local_high_r <= wdata;
        `TFR_ADDR_LOCAL_LOW: local_low_r <= wdata;
        `TFR_ADDR_LOCAL_OVT: local_ovt_r <= wdata;
        `TFR_ADDR_REMOTE_HIGH: remote_high_r <= wdata;
        `TFR_ADDR_REMOTE_LOW: remote_low_r <= wdata;
        `TFR_ADDR_REMOTE_OVT: remote_ovt_r <= wdata;
        `TFR_ADDR_FAN_SETUP: fan_setup_r <= wdata;
        `TFR_ADDR_FAN_SPEED: fan_speed_r <= wdata;
        `TFR_ADDR_FAN_SMOOTH: fan_smooth_r <= wdata;
        `TFR_ADDR_LOCAL_RANGE: local_range_r <= wdata;
        `TFR_ADDR_REMOTE_RANGE: remote_range_r <= wdata;
        `TFR_ADDR_REVISION: ovt_fan_r <= wdata[7]; // RQ14
        // identity, value, flag and unlisted addresses ignore writes
        default: ;
      endcase
    end
  end

  // tach period: a fresh measurement wins over a software write
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      fan_count_r <= 8'h00;
    end
    else if (fan_count_valid && cfg1_r[`TFR_CFG1_MONITOR])
    begin
      fan_count_r <= fan_count_in; // RQ16 RQ1
    end
    else if (wr && addr == `TFR_ADDR_FAN_COUNT)
    begin
      fan_count_r <= wdata;
    end
  end

  // sticky event flags, cleared by a read except the diode flag; a new event wins over the clear
  always_comb
  begin
    flags1_src = cfg1_r[`TFR_CFG1_MONITOR] ? flags_one_set : 8'h00;
    // diode fault detection does not depend on monitoring
    flags1_src[`TFR_FLAG1_DIODE] = flags_one_set[`TFR_FLAG1_DIODE];
    flags1_src[`TFR_FLAG1_FAN_FAIL] = fan_fail_event;
    flags1_clr = 8'h00;
    flags2_clr = 8'h00;
    if (rd && addr == `TFR_ADDR_FLAGS1)
    begin
      flags1_clr = 8'hFF;
      // diode error is only checked at power-up and survives reads
      flags1_clr[`TFR_FLAG1_DIODE] = 1'b0;
    end
    if (rd && addr == `TFR_ADDR_FLAGS2)
    begin
      flags2_clr = 8'hFF;
    end
  end

  always_ff @(posedge clk)
  begin
    if (init)
    begin
      flags1_r <= 8'h00;
      flags2_r <= 8'h00;
    end
    else
    begin
      flags1_r <= (flags1_r & ~flags1_clr) | flags1_src;
      flags2_r <= (flags2_r & ~flags2_clr)
        | {flags_two_set & {2{cfg1_r[`TFR_CFG1_MONITOR]}}, 6'h00};
    end
  end

  // per-channel interrupt enables; local owns bits 6,7 and flag two bit 6
  assign local_int = cfg2_r[`TFR_CFG2_LOCAL_INT]
    & (flags1_r[6] | flags1_r[7] | flags2_r[6]);
  assign remote_int = cfg2_r[`TFR_CFG2_REMOTE_INT]
    & (|flags1_r[5:2]);

  // interrupt pin: low while any enabled flag stands
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      int_n <= 1'b1;
    end
    else
    begin
      int_n <= ~(cfg1_r[`TFR_CFG1_INT_EN] & (local_int | remote_int
        | flags1_r[0] | flags1_r[1] | flags2_r[7])); // RQ2
    end
  end

  // consecutive failure tracking; a passing measurement restarts it
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      fail_run_r <= 3'h0;
      fan_state_r <= TFR_FAN_OK;
    end
    else
    begin
      case (fan_state_r)
        TFR_FAN_OK:
        begin
          if (fan_fail_event)
          begin
            fail_run_r <= 3'h1;
            fan_state_r <= TFR_FAN_FAILING;
          end
        end
        TFR_FAN_FAILING:
        begin
          if (fan_pass_event)
          begin
            fail_run_r <= 3'h0;
            fan_state_r <= TFR_FAN_OK;
          end
          else if (fan_fail_event)
          begin
            fail_run_r <= fail_run_r + 3'h1;
            if (fail_run_r + 3'h1 == `TFR_FAIL_COUNT)
            begin
              fan_state_r <= TFR_FAN_FAULT; // RQ24
            end
          end
        end
        TFR_FAN_FAULT:
        begin
          // recovery negates the pin; measuring continues meanwhile
          if (fan_pass_event)
          begin
            fail_run_r <= 3'h0;
            fan_state_r <= TFR_FAN_OK;
          end
        end
        default:
        begin
          fail_run_r <= 3'h0;
          fan_state_r <= TFR_FAN_OK;
        end
      endcase
    end
  end

  // open-drain fan-failure pin: data always low, enable drives it
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      fan_fail_oe <= 1'b0;
      fan_fail_n_out <= 1'b0;
    end
    else
    begin
      fan_fail_oe <= cfg1_r[`TFR_CFG1_FAIL_EN]
        & (fan_state_r == TFR_FAN_FAULT); // RQ6 RQ24
      fan_fail_n_out <= 1'b0;
    end
  end

  // fan drive polarity: non-inverted output sits low while the fan is on
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      fan_drive_out <= 1'b1;
    end
    else
    begin
      fan_drive_out <= cfg1_r[`TFR_CFG1_INVERT] ? fan_drive_on
        : ~fan_drive_on; // RQ4 RQ5
    end
  end

  // configuration decoded for the control loop and sensing logic
  always_ff @(posedge clk)
  begin
    if (init)
    begin
      monitor_enable <= 1'b0;
      speed_sense_analog_select <= 1'b0;
      control_source <= 2'h0;
      automatic_or_software_control <= 1'b1;
      software_sets_duty <= 1'b0;
      software_sets_speed <= 1'b0;
      overtemp_to_fan_enable <= 1'b0;
    end
    else
    begin
      monitor_enable <= cfg1_r[`TFR_CFG1_MONITOR]; // RQ1
      speed_sense_analog_select <= cfg1_r[`TFR_CFG1_ANALOG]; // RQ3
      control_source <= cfg1_r[`TFR_CFG1_SRC_HI:`TFR_CFG1_SRC_LO]; // RQ7
      automatic_or_software_control <= cfg1_r[`TFR_CFG1_AUTO]; // RQ9
      // codes 01 and 10 leave software with neither target
      software_sets_duty <= ~cfg1_r[`TFR_CFG1_AUTO]
        & (cfg1_r[`TFR_CFG1_SRC_HI:`TFR_CFG1_SRC_LO] == 2'h0); // RQ8
      software_sets_speed <= ~cfg1_r[`TFR_CFG1_AUTO]
        & (cfg1_r[`TFR_CFG1_SRC_HI:`TFR_CFG1_SRC_LO] == 2'h3); // RQ8
      overtemp_to_fan_enable <= ovt_fan_r; // RQ14
    end
  end

  // read multiplexer
  always_comb
  begin
    case (addr)
      `TFR_ADDR_CFG1: rdata_nxt = cfg1_r;
      `TFR_ADDR_CFG2: rdata_nxt = cfg2_r;
      `TFR_ADDR_FLAGS1: rdata_nxt = flags1_r;
      `TFR_ADDR_FLAGS2: rdata_nxt = flags2_r;
      `TFR_ADDR_FRACTION: rdata_nxt = temp_fraction_in; // RQ20
      `TFR_ADDR_FAN_COUNT: rdata_nxt = fan_count_r; // RQ16
      `TFR_ADDR_LOCAL_TEMP: rdata_nxt = local_temp_upper_bits; // RQ18
      `TFR_ADDR_REMOTE_TEMP: rdata_nxt = remote_temp_upper_bits; // RQ19
      `TFR_ADDR_LOCAL_OFS: rdata_nxt = local_ofs_r;
      `TFR_ADDR_REMOTE_OFS: rdata_nxt = remote_ofs_r;
      `TFR_ADDR_FAN_LIMIT: rdata_nxt = fan_limit_r;
      `TFR_ADDR_LOCAL_HIGH: rdata_nxt = local_high_r;
      `TFR_ADDR_LOCAL_LOW: rdata_nxt = local_low_r;
      `TFR_ADDR_LOCAL_OVT: rdata_nxt = local_ovt_r;
      `TFR_ADDR_REMOTE_HIGH: rdata_nxt = remote_high_r;
      `TFR_ADDR_REMOTE_LOW: rdata_nxt = remote_low_r;
      `TFR_ADDR_REMOTE_OVT: rdata_nxt = remote_ovt_r;
      `TFR_ADDR_FAN_SETUP: rdata_nxt = fan_setup_r;
      `TFR_ADDR_FAN_SPEED: rdata_nxt = fan_speed_r;
      `TFR_ADDR_FAN_SMOOTH: rdata_nxt = fan_smooth_r;
      `TFR_ADDR_LOCAL_RANGE: rdata_nxt = local_range_r;
      `TFR_ADDR_REMOTE_RANGE: rdata_nxt = remote_range_r;
      `TFR_ADDR_PART_ID: rdata_nxt = PART_CODE; // RQ11
      `TFR_ADDR_MAKER_ID: rdata_nxt = MAKER_CODE; // RQ12
      `TFR_ADDR_REVISION: rdata_nxt = {ovt_fan_r, 3'h0, REVISION}; // RQ13
      // factory test location reads as zero too
      default: rdata_nxt = 8'h00; // RQ25 RQ15
    endcase
  end

  // read data stand only in the cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      rdata <= 8'h00;
    end
    else
    begin
      rdata <= rd ? rdata_nxt : 8'h00;
    end
  end

endmodule

// >>> test/tfr_regs_assertions.sv
// assertion checker for the register bank ports
`timescale 1ns/1ps
module tfr_regs_assertions
  import tfr_pkg::*;
#(
  parameter tfr_byte_t PART_CODE = 8'hA5,
  parameter tfr_byte_t MAKER_CODE = 8'h5A,
  parameter logic [3:0] REVISION = 4'h1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] fan_count_in,
  input wire logic fan_count_valid,
  input wire logic fan_drive_on,
  input wire logic monitor_enable,
  input wire logic speed_sense_analog_select,
  input wire logic [1:0] control_source,
  input wire logic automatic_or_software_control,
  input wire logic software_sets_duty,
  input wire logic software_sets_speed,
  input wire logic fan_drive_out,
  input wire logic int_n,
  input wire logic fan_fail_n_out,
  input wire logic fan_fail_oe
);
  logic [7:0] cfg_r;
  logic [7:0] lim_r;
  logic [2:0] cnt_r;
  logic run_r;
  logic srst_r;

  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);

  // soft reset lands one edge after the write that requests it
  always_ff @(posedge clk)
    srst_r <= !reset && wr && addr == 8'h01 && wdata[7];

  // shadow copies of config one and the tach limit
  always_ff @(posedge clk)
    if (reset || srst_r)
      cfg_r <= 8'h90;
    else if (wr && addr == 8'h00)
      cfg_r <= wdata;

  always_ff @(posedge clk)
    if (reset || srst_r)
      lim_r <= 8'hFF;
    else if (wr && addr == 8'h10)
      lim_r <= wdata;

  // consecutive failed measurements, saturating
  always_ff @(posedge clk)
    if (reset || srst_r)
      cnt_r <= 3'h0;
    else if (fan_count_valid && cfg_r[0])
      cnt_r <= (fan_count_in <= lim_r) ? 3'h0 :
               (cnt_r == 3'h7) ? cnt_r : cnt_r + 3'h1;

  // masks $past over the first edge after either reset
  always_ff @(posedge clk)
    run_r <= !reset && !srst_r;

  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_unlisted_zero: assert property (rd && addr > 8'h3F |=>
    rdata == 8'h00) else $error("unlisted address read nonzero");
  a_part_code: assert property (rd && addr == 8'h3D |=>
    rdata == PART_CODE) else $error("part code wrong");
  a_maker_code: assert property (rd && addr == 8'h3E |=>
    rdata == MAKER_CODE) else $error("maker code wrong");
  a_revision_bits: assert property (rd && addr == 8'h3F |=>
    rdata[3:0] == REVISION) else $error("revision bits wrong");
  a_drive_polarity: assert property (run_r |-> fan_drive_out ==
    ($past(fan_drive_on) ~^ $past(cfg_r[3])))
    else $error("fan drive polarity wrong");
  a_cfg_outputs: assert property (run_r |->
    {automatic_or_software_control, control_source,
    speed_sense_analog_select, monitor_enable} ==
    $past({cfg_r[7:5], cfg_r[2], cfg_r[0]}))
    else $error("config outputs do not follow register");
  a_software_mode: assert property (run_r |->
    software_sets_duty == $past(cfg_r[7:5] == 3'b000) &&
    software_sets_speed == $past(cfg_r[7:5] == 3'b011))
    else $error("software mode decode wrong");
  a_fail_gated: assert property (fan_fail_oe |->
    $past(cfg_r[4]) && !fan_fail_n_out) else $error("fail pin not gated");
  a_fail_count: assert property ($rose(fan_fail_oe) |->
    cnt_r >= 3'h5) else $error("fail pin before five failures");
  a_int_gated: assert property (!int_n |-> $past(cfg_r[1]))
    else $error("interrupt output while disabled");

  c_fail_pin: cover property ($rose(fan_fail_oe));
  c_int_low: cover property (!int_n);
  c_sw_speed: cover property (software_sets_speed);
endmodule

bind tfr_regs tfr_regs_assertions #(.PART_CODE(PART_CODE),
  .MAKER_CODE(MAKER_CODE), .REVISION(REVISION)) u_chk (.*);

// >>> test/tfr_host.sv
// host model driving the register bus
`timescale 1ns/1ps
module tfr_host
(
  input wire logic clk,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end

  // idle bus shows scrambled values, not the last ones
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    if (a == 8'h07)
      return;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    d = 8'h00;
    if (a == 8'h07)
      return;
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge clk);
    d = rdata;
  endtask
endmodule

// >>> test/tfr_regs_tb_top.sv
// self-checking testbench for the register bank
`timescale 1ns/1ps
module tfr_regs_tb_top
  import tfr_pkg::*;
;
  localparam tfr_byte_t PID = 8'hC3; // arbitrary value
  localparam tfr_byte_t MID = 8'h96; // arbitrary value
  localparam logic [3:0] REV = 4'h7;
  localparam tfr_byte_t RA [16] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10,
    8'h14, 8'h15, 8'h16, 8'h18, 8'h19, 8'h1A, 8'h20, 8'h22, 8'h23,
    8'h24, 8'h25};
  localparam tfr_byte_t RE [16] = '{8'h90, 8'h7F, 8'h00, 8'h00, 8'hFF,
    8'h3C, 8'h00, 8'h46, 8'h50, 8'h00, 8'h64, 8'h5D, 8'h55, 8'h55,
    8'h41, 8'h61};
  localparam tfr_byte_t CFG [8] = '{8'h01, 8'h04, 8'h08, 8'h60, 8'h00,
    8'hE8, 8'h9F, 8'h18};
  logic clk, reset, wr, rd, fv, on, mon, ana, auto, sd, ss, ote, fdo;
  logic int_n, ffn, ffoe;
  logic [7:0] addr, wdata, rdata, lt, rt, fr, fc;
  logic [1:0] src;
  int mismatches, cmp_count;

  tfr_regs #(.PART_CODE(PID), .MAKER_CODE(MID), .REVISION(REV)) u_dut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .local_temp_upper_bits(lt),
    .remote_temp_upper_bits(rt), .temp_fraction_in(fr),
    .fan_count_in(fc), .fan_count_valid(fv), .flags_one_set(8'h00),
    .flags_two_set(2'h0), .fan_drive_on(on), .monitor_enable(mon),
    .speed_sense_analog_select(ana), .control_source(src),
    .automatic_or_software_control(auto), .software_sets_duty(sd),
    .software_sets_speed(ss), .overtemp_to_fan_enable(ote),
    .fan_drive_out(fdo), .int_n(int_n), .fan_fail_n_out(ffn),
    .fan_fail_oe(ffoe));
  tfr_host u_host (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input string n, input tfr_byte_t s, input tfr_byte_t e);
    cmp_count++;
    if (s !== e)
    begin
      $display("[ERR] %s expected %h seen %h", n, e, s);
      mismatches++;
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rdchk(input tfr_byte_t a, input tfr_byte_t e, input string n);
    tfr_byte_t d;
    u_host.rd_reg(a, d);
    chk(n, d, e);
  endtask

  task automatic wreg(input tfr_byte_t a, input tfr_byte_t d);
    u_host.wr_reg(a, d);
  endtask

  task automatic pulse(input tfr_byte_t v);
    @(posedge clk);
    fc <= v;
    fv <= 1'b1;
    @(posedge clk);
    fv <= 1'b0;
    settle(3);
  endtask

  task automatic t_reset;
    for (int i = 0; i < 16; i++)
      rdchk(RA[i], RE[i], "reset value");
    chk("reset outputs",
      {2'b00, auto, mon, int_n, ffoe, fdo, ana}, 8'h2A);
    $display("test reset done");
  endtask

  task automatic t_config;
    tfr_byte_t c;
    for (int i = 0; i < 8; i++)
    begin
      c = CFG[i];
      on <= i[0];
      wreg(8'h00, c);
      settle(2);
      chk("config outputs",
        {auto, src, ana, mon, sd, ss, fdo},
        {c[7:5], c[2], c[0], c[7:5] == 3'b000, c[7:5] == 3'b011,
        on ~^ c[3]});
      rdchk(8'h00, c, "config readback");
    end
    $display("test config done");
  endtask

  task automatic t_ident;
    wreg(8'h3D, ~PID);
    wreg(8'h3E, ~MID);
    wreg(8'h3F, 8'h8F);
    rdchk(8'h3D, PID, "part code");
    rdchk(8'h3E, MID, "maker code");
    rdchk(8'h3F, {4'h8, REV}, "revision");
    chk("overtemp enable", {7'h00, ote}, 8'h01);
    wreg(8'h3F, 8'h70);
    rdchk(8'h3F, {4'h0, REV}, "revision clear");
    wreg(8'h40, 8'hAA);
    rdchk(8'h40, 8'h00, "unlisted");
    rdchk(8'hFF, 8'h00, "unlisted top");
    $display("test ident done");
  endtask

  task automatic t_values;
    lt <= 8'h5A;
    rt <= 8'hB4;
    fr <= 8'hC0;
    wreg(8'h0A, 8'h00);
    wreg(8'h0B, 8'h00);
    wreg(8'h06, 8'h00);
    rdchk(8'h0A, 8'h5A, "local temp");
    rdchk(8'h0B, 8'hB4, "remote temp");
    rdchk(8'h06, 8'hC0, "fraction");
    wreg(8'h0D, 8'hA3);
    wreg(8'h0E, 8'h3A);
    rdchk(8'h0D, 8'hA3, "local offset");
    rdchk(8'h0E, 8'h3A, "remote offset");
    wreg(8'h00, 8'h01);
    pulse(8'h37);
    rdchk(8'h08, 8'h37, "fan count");
    wreg(8'h08, 8'h12);
    rdchk(8'h08, 8'h12, "fan count write");
    $display("test values done");
  endtask

  task automatic t_fan_fail;
    tfr_byte_t d;
    wreg(8'h10, 8'hFE);
    wreg(8'h00, 8'h13);
    repeat (4) pulse(8'hFF);
    chk("int low", {7'h00, int_n}, 8'h00);
    chk("fail after four", {7'h00, ffoe}, 8'h00);
    u_host.rd_reg(8'h02, d);
    chk("fan fault flag", d & 8'h02, 8'h02);
    pulse(8'hFE);
    repeat (4) pulse(8'hFF);
    chk("limit equal passes", {7'h00, ffoe}, 8'h00);
    pulse(8'hFF);
    chk("fail pin", {6'h00, ffoe, ffn}, 8'h02);
    wreg(8'h00, 8'h03);
    settle(2);
    chk("fail pin disabled", {7'h00, ffoe}, 8'h00);
    wreg(8'h00, 8'h13);
    settle(2);
    chk("fail pin enabled", {7'h00, ffoe}, 8'h01);
    pulse(8'h10);
    chk("fail pin recovers", {7'h00, ffoe}, 8'h00);
    wreg(8'h00, 8'h11);
    u_host.rd_reg(8'h02, d);
    pulse(8'hFF);
    chk("int masked", {7'h00, int_n}, 8'h01);
    // soft reset must bring config back to its power-on values
    wreg(8'h01, 8'h80);
    rdchk(8'h00, 8'h90, "soft reset config one");
    rdchk(8'h01, 8'h7F, "soft reset config two");
    $display("test fan fail done");
  endtask

  task automatic results;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    mismatches++;
    results;
  end

  initial
  begin
    reset = 1'b1;
    lt = 8'h00;
    rt = 8'h00;
    fr = 8'h00;
    fc = 8'h00;
    fv = 1'b0;
    on = 1'b0;
    mismatches = 0;
    cmp_count = 0;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    settle(1);
    t_reset;
    t_config;
    t_ident;
    t_values;
    t_fan_fail;
    results;
  end
endmodule
